/* display_lvds_serdes_link.sv */
// Purpose: Serial display link, transmitter and receiver halves
// Assumes: pixel clock period of at least 7 core_clk cycles
// Notes: core_clk stands in for the PLL fast clock, one slot per cycle
//
// How it works
// (RULE_01) Transmitter captures word on pixel clock fall
// (RULE_02) Parallel word is 21 bits: RGB plus sync
// (RULE_03) Three data lanes, each a complementary pair
// (RULE_04) Seven slots per lane each pixel period
// (RULE_05) Pixel clock forwarded on its own pair
// (RULE_06) Receiver deserializes lanes using forwarded clock
// (RULE_07) Receiver outputs rebuilt word, same bit order
// (RULE_08) Output pixel clock fall marks word capture
// (RULE_09) Sleep low disables all outputs of a half
// (RULE_10) Controller pixel period from 15 to 50 ns; the controller model here runs a 320 ns period
// (RULE_11) Controller clock phases within 0.35 to 0.65
// (RULE_12) Transmitter locks within 10 ms; invalid before
// (RULE_13) Receiver locks within 10 ms; invalid before
// (RULE_14) Output pixel clock period matches transmit clock
// (RULE_15) Every pixel clock cycle sends a word
// (RULE_16) Lane rate is seven bits per clock
// (RULE_17) Bit index equals lane times seven plus slot
// (RULE_18) Forwarded clock repeats a slot-aligned pattern
`timescale 1ns/100ps
module display_lvds_serdes_link #(
  parameter int LOCK_CYCLES = display_link_pkg::LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic txSleepN,
  input wire logic pixelClkIn,
  input wire display_link_pkg::pixel_word_t parPixelIn, // RULE_02
  output display_link_pkg::link_t txLink,
  output logic txLinkOe,
  input wire logic rxSleepN,
  input wire display_link_pkg::link_t rxLink,
  output display_link_pkg::pixel_word_t parPixelOut,
  output logic pixelClkOut,
  output logic rxOutOe
);

  // ---------------- Transmitter ----------------
  logic pclkS1_reg, pclkS2_reg, pclkPrev_reg;
  logic txSleepS1_reg, txSleepS2_reg;
  display_link_pkg::pixel_word_t dataS1_reg, dataS2_reg;
  display_link_pkg::pixel_word_t word_reg, word_next;
  logic [2:0] slot_reg, slot_next;
  logic [2:0] laneBits_reg, laneBits_next;
  logic fwdBit_reg, fwdBit_next;
  logic txFall, txLocked;

  // Pins pass two flops; data is synced with the clock so both line up
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pclkS1_reg <= 1'b0;
      pclkS2_reg <= 1'b0;
      pclkPrev_reg <= 1'b0;
      txSleepS1_reg <= 1'b0;
      txSleepS2_reg <= 1'b0;
      dataS1_reg <= '0;
      dataS2_reg <= '0;
    end else begin
      pclkS1_reg <= pixelClkIn;
      pclkS2_reg <= pclkS1_reg;
      pclkPrev_reg <= pclkS2_reg;
      txSleepS1_reg <= txSleepN;
      txSleepS2_reg <= txSleepS1_reg;
      dataS1_reg <= parPixelIn;
      dataS2_reg <= dataS1_reg;
    end
  end

  assign txFall = pclkPrev_reg & ~pclkS2_reg; // RULE_01

  link_lock_tracker #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) txLock (
    .core_clk(core_clk),
    .resetn(resetn),
    .awake(txSleepS2_reg),
    .strobe(txFall),
    .locked(txLocked)
  );

  // Serializer: slot 0 goes out the cycle after the fall, then one slot per cycle
  always_comb begin
    word_next = word_reg;
    slot_next = slot_reg;
    laneBits_next = laneBits_reg;
    fwdBit_next = fwdBit_reg;
    if (!txLocked) begin
      // Serial output held quiet until lock
      slot_next = display_link_pkg::SLOT_IDLE; // RULE_12
      laneBits_next = 3'h0;
      fwdBit_next = 1'b0;
    end else if (txFall) begin
      word_next = dataS2_reg; // RULE_15
      slot_next = 3'h1;
      for (int l = 0; l < display_link_pkg::LANES; l++) begin
        laneBits_next[l] = display_link_pkg::laneBit(dataS2_reg, l, 0); // RULE_17
      end
      fwdBit_next = display_link_pkg::FWD_PATTERN[0]; // RULE_18
    end else if (slot_reg != display_link_pkg::SLOT_IDLE) begin
      for (int l = 0; l < display_link_pkg::LANES; l++) begin
        laneBits_next[l] = display_link_pkg::laneBit(word_reg, l, int'(slot_reg)); // RULE_04
      end
      fwdBit_next = display_link_pkg::FWD_PATTERN[slot_reg]; // RULE_05
      slot_next = slot_reg + 3'h1; // RULE_16
    end
  end

  // Serializer registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      word_reg <= '0;
      slot_reg <= display_link_pkg::SLOT_IDLE;
      laneBits_reg <= 3'h0;
      fwdBit_reg <= 1'b0;
    end else begin
      word_reg <= word_next;
      slot_reg <= slot_next;
      laneBits_reg <= laneBits_next;
      fwdBit_reg <= fwdBit_next;
    end
  end

  // Complementary pairs; the pad turns off while sleeping
  assign txLink.lanePos = laneBits_reg; // RULE_03
  assign txLink.laneNeg = ~laneBits_reg;
  assign txLink.fwdClkPos = fwdBit_reg;
  assign txLink.fwdClkNeg = ~fwdBit_reg;
  assign txLinkOe = txSleepS2_reg; // RULE_09

  // ---------------- Receiver ----------------
  display_link_pkg::link_t rxS1_reg, rxS2_reg;
  logic rxSleepS1_reg, rxSleepS2_reg;
  logic fwdPrev_reg;
  logic [6:0] shift_reg [3], shift_next [3];
  logic [2:0] rxSlot_reg, rxSlot_next;
  display_link_pkg::pixel_word_t out_reg, out_next;
  logic pclkOut_reg, pclkOut_next;
  logic [1:0] hiCnt_reg, hiCnt_next;
  logic rxFall, rxLocked, rxLatch;
  logic [2:0] rxBits;
  logic [2:0] curSlot;

  // Link pins pass two flops before use
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rxS1_reg <= '0;
      rxS2_reg <= '0;
      rxSleepS1_reg <= 1'b0;
      rxSleepS2_reg <= 1'b0;
      fwdPrev_reg <= 1'b0;
    end else begin
      rxS1_reg <= rxLink;
      rxS2_reg <= rxS1_reg;
      rxSleepS1_reg <= rxSleepN;
      rxSleepS2_reg <= rxSleepS1_reg;
      fwdPrev_reg <= rxS2_reg.fwdClkPos;
    end
  end

  // A fall of the forwarded clock is slot 2; slot 6 closes the word
  assign rxFall = fwdPrev_reg & ~rxS2_reg.fwdClkPos; // RULE_18
  assign rxBits = rxS2_reg.lanePos & ~rxS2_reg.laneNeg; // RULE_06
  assign curSlot = rxFall ? display_link_pkg::FWD_FALL_SLOT :
                   (rxSlot_reg == display_link_pkg::SLOT_IDLE ? rxSlot_reg : rxSlot_reg + 3'h1);
  assign rxLatch = rxLocked && (curSlot == 3'h6);

  link_lock_tracker #(
    .LOCK_CYCLES(LOCK_CYCLES)
  ) rxLock (
    .core_clk(core_clk),
    .resetn(resetn),
    .awake(rxSleepS2_reg),
    .strobe(rxFall),
    .locked(rxLocked)
  );

  // Deserializer and regenerated pixel clock
  always_comb begin
    out_next = out_reg;
    pclkOut_next = pclkOut_reg;
    hiCnt_next = hiCnt_reg;
    rxSlot_next = curSlot;
    for (int l = 0; l < display_link_pkg::LANES; l++) begin
      shift_next[l] = {shift_reg[l][5:0], rxBits[l]};
    end
    if (!rxLocked) begin
      // Outputs held low until lock
      out_next = '0; // RULE_13
      pclkOut_next = 1'b0;
      hiCnt_next = 2'h0;
    end else if (rxLatch) begin
      for (int l = 0; l < display_link_pkg::LANES; l++) begin
        for (int s = 0; s < display_link_pkg::SLOTS; s++) begin
          out_next[l * display_link_pkg::SLOTS + s] = shift_next[l][6 - s]; // RULE_07
        end
      end
      pclkOut_next = 1'b1; // RULE_14
      hiCnt_next = 2'(display_link_pkg::RX_HIGH_CYC - 1);
    end else if (pclkOut_reg) begin
      // Fall lands mid-word, so data is stable around it
      if (hiCnt_reg == 2'h0) begin
        pclkOut_next = 1'b0; // RULE_08
      end else begin
        hiCnt_next = hiCnt_reg - 2'h1;
      end
    end
    if (rxLatch) begin
      rxSlot_next = display_link_pkg::SLOT_IDLE;
    end
  end

  // Receiver registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int l = 0; l < display_link_pkg::LANES; l++) begin
        shift_reg[l] <= 7'h00;
      end
      rxSlot_reg <= display_link_pkg::SLOT_IDLE;
      out_reg <= '0;
      pclkOut_reg <= 1'b0;
      hiCnt_reg <= 2'h0;
    end else begin
      for (int l = 0; l < display_link_pkg::LANES; l++) begin
        shift_reg[l] <= shift_next[l];
      end
      rxSlot_reg <= rxSlot_next;
      out_reg <= out_next;
      pclkOut_reg <= pclkOut_next;
      hiCnt_reg <= hiCnt_next;
    end
  end

  assign parPixelOut = out_reg;
  assign pixelClkOut = pclkOut_reg;
  assign rxOutOe = rxSleepS2_reg; // RULE_09

  // ---------------- Checks ----------------
  sequence sTxFall;
    txFall && txLocked;
  endsequence

  sequence sFwdPattern;
    txLink.fwdClkPos [*2] ##1 !txLink.fwdClkPos [*3] ##1 txLink.fwdClkPos [*2];
  endsequence

  a_tx_capture: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
    sTxFall |=> word_reg == $past(dataS2_reg))
    else $error("word not captured on pixel clock fall");

  a_tx_rise_idle: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_01
    !txFall |=> $stable(word_reg))
    else $error("word changed without a pixel clock fall");

  a_lane_pairs: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_03
    txLink.laneNeg == ~txLink.lanePos && txLink.fwdClkNeg == ~txLink.fwdClkPos)
    else $error("differential pair not complementary");

  a_fwd_hold: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_18
    txLocked && !txFall && slot_reg == display_link_pkg::SLOT_IDLE |=> $stable(txLink.fwdClkPos))
    else $error("forwarded clock moved between words");

  a_fwd_slots: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_05
    sTxFall |=> sFwdPattern)
    else $error("forwarded clock pattern wrong");

  a_seven_slots: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_04
    sTxFall |=> slot_reg == 3'h1 ##5 slot_reg == 3'h6 ##1 slot_reg == 3'h7)
    else $error("lane did not send seven slots");

  a_lane_map: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_17
    sTxFall |=> txLink.lanePos[1] == word_reg[7] ##1 txLink.lanePos[2] == word_reg[15])
    else $error("lane slot carries wrong word bit");

  a_tx_sleep: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_09
    !txSleepN ##1 !txSleepN |=> !txLinkOe)
    else $error("transmitter drives while asleep");

  a_rx_word: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_07
    rxLatch |=> parPixelOut[0] == $past(shift_reg[0][5]) && parPixelOut[20] == $past(rxBits[2]))
    else $error("rebuilt word bit order wrong");

  a_rx_clk_high: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_08
    $rose(pixelClkOut) |-> pixelClkOut [*3] ##1 (!pixelClkOut && $stable(parPixelOut)))
    else $error("pixel clock out shape wrong");

endmodule // display_lvds_serdes_link

/* display_link_pkg.sv */
// Purpose: Shared types and constants for the display serial link
// Assumes: core_clk at 25 MHz; all timing derived from its period
// Notes: The lane and slot map is fixed; the receiver inverts it exactly
package display_link_pkg;

  // Core clock period
  localparam int CORE_CLK_NS = 40;

  // Serial bit slots per pixel period and number of data lanes
  localparam int SLOTS = 7;
  localparam int LANES = 3;
  localparam int WORD_BITS = 21;

  // Longest PLL lock time, rounded down to whole cycles
  localparam int LOCK_MAX_NS = 10000000;
  localparam int LOCK_CYC = LOCK_MAX_NS / CORE_CLK_NS;

  // Lock is dropped when no pixel or forwarded clock fall shows for this long
  localparam int IDLE_NS = 2560;
  localparam int IDLE_CYC = IDLE_NS / CORE_CLK_NS;

  // Forwarded clock slot pattern, slot 0 in bit 0: high 2, low 3, high 2
  localparam logic [6:0] FWD_PATTERN = 7'h63;
  // Slot in which the forwarded clock falls
  localparam logic [2:0] FWD_FALL_SLOT = 3'h2;
  // Slot code meaning no slot in flight
  localparam logic [2:0] SLOT_IDLE = 3'h7;
  // Cycles the regenerated pixel clock stays high after a new word
  localparam int RX_HIGH_CYC = 3;

  // Lock tracker states
  typedef enum logic [2:0] {
    LK_DOWN = 3'b001,
    LK_SEEK = 3'b010,
    LK_RUN = 3'b100
  } lock_state_t;

  // Parallel pixel word, red in bits 5:0 and control in bits 20:18
  typedef struct packed {
    logic pixelValid;
    logic frameSync;
    logic lineSync;
    logic [5:0] blue;
    logic [5:0] green;
    logic [5:0] red;
  } pixel_word_t;

  // Differential link: three data pairs and the forwarded clock pair
  typedef struct packed {
    logic [2:0] lanePos;
    logic [2:0] laneNeg;
    logic fwdClkPos;
    logic fwdClkNeg;
  } link_t;

  // Word bit carried by a lane in a slot
  function automatic logic laneBit(input pixel_word_t w, input int lane, input int slot);
    laneBit = w[lane * SLOTS + slot];
  endfunction

endpackage

/* link_lock_tracker.sv */
// Purpose: Models PLL lock on a sampled pixel or forwarded clock
// Assumes: awake and strobe are already on core_clk
// Notes: Lock needs a steady clock for the whole lock time
`timescale 1ns/100ps
module link_lock_tracker #(
  parameter int LOCK_CYCLES = display_link_pkg::LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic awake,
  input wire logic strobe,
  output logic locked
);

  display_link_pkg::lock_state_t state_reg, state_next;
  logic [17:0] cnt_reg, cnt_next;
  logic [6:0] idle_reg, idle_next;
  logic stalled;

  assign stalled = (idle_reg == 7'(display_link_pkg::IDLE_CYC));
  assign locked = (state_reg == display_link_pkg::LK_RUN);

  // Lock sequencing; a stalled clock restarts the count
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    idle_next = strobe ? 7'h00 : (stalled ? idle_reg : idle_reg + 7'h01);
    unique case (state_reg)
      display_link_pkg::LK_DOWN: begin
        cnt_next = 18'h00000;
        if (awake) begin
          state_next = display_link_pkg::LK_SEEK;
        end
      end
      display_link_pkg::LK_SEEK: begin
        if (!awake) begin
          state_next = display_link_pkg::LK_DOWN;
        end else if (stalled) begin
          cnt_next = 18'h00000;
        end else if (cnt_reg == 18'(LOCK_CYCLES - 1)) begin
          state_next = display_link_pkg::LK_RUN;
        end else begin
          cnt_next = cnt_reg + 18'h00001;
        end
      end
      display_link_pkg::LK_RUN: begin
        cnt_next = 18'h00000;
        if (!awake) begin
          state_next = display_link_pkg::LK_DOWN;
        end else if (stalled) begin
          state_next = display_link_pkg::LK_SEEK;
        end
      end
      default: begin
        state_next = display_link_pkg::LK_DOWN;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= display_link_pkg::LK_DOWN;
      cnt_reg <= 18'h00000;
      idle_reg <= 7'h00;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      idle_reg <= idle_next;
    end
  end

  a_lock_time: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_12
    $rose(locked) |-> $past(cnt_reg) == 18'(LOCK_CYCLES - 1) && $past(awake))
    else $error("lock reached before the lock count ran out");

  a_lock_sleep: assert property (@(posedge core_clk) disable iff (!resetn) // RULE_13
    !awake |=> !locked)
    else $error("lock held while asleep");

endmodule // link_lock_tracker

/* pixel_source.sv */
// Purpose: Graphics controller model driving the pixel clock and word
// Assumes: 320 ns pixel period at even duty
// Notes: Clock stands still high while stopped; word changes only as a high half starts
`timescale 1ns/100ps
module pixel_source (
  input wire logic enable,
  input wire display_link_pkg::pixel_word_t nextWord,
  output logic pixelClk,
  output display_link_pkg::pixel_word_t parWord
);
  // Offset keeps pixel edges clear of core_clk edges
  initial begin
    pixelClk = 1'b1;
    parWord = '0;
    #7;
    forever begin
      if (enable) begin
        pixelClk = 1'b1;
        parWord = nextWord;
        #160;
        pixelClk = 1'b0;
        #160;
      end else begin
        pixelClk = 1'b1;
        #40;
      end
    end
  end
endmodule // pixel_source

/* tb_display_lvds_serdes_link.sv */
// Purpose: Self-checking bench for the display serial link
// Assumes: LOCK_CYCLES of 20, pixel period of 8 core cycles
// Notes: Transmit link is looped back into the receiver
`timescale 1ns/100ps
module tb_display_lvds_serdes_link;
  logic core_clk, resetn, txSleepN, rxSleepN, enable, pixelClkIn;
  logic txLinkOe, pixelClkOut, rxOutOe, prevClkOut, tracking, checking;
  logic [6:0] fwdSeq;
  display_link_pkg::pixel_word_t parPixelIn, nextWord, parPixelOut, txWord;
  display_link_pkg::link_t txLink, rxLink, heldLink;
  display_link_pkg::link_t hist [0:6];
  display_link_pkg::pixel_word_t txExp [$];
  display_link_pkg::pixel_word_t rxExp [$];
  int err_count, comparisons, txSeen, rxSeen, highCyc, periodCyc;

  display_lvds_serdes_link #(.LOCK_CYCLES(20)) display_lvds_serdes_link_inst (
    .core_clk(core_clk), .resetn(resetn), .txSleepN(txSleepN), .pixelClkIn(pixelClkIn),
    .parPixelIn(parPixelIn), .txLink(txLink), .txLinkOe(txLinkOe), .rxSleepN(rxSleepN),
    .rxLink(rxLink), .parPixelOut(parPixelOut), .pixelClkOut(pixelClkOut), .rxOutOe(rxOutOe));
  pixel_source pixel_source_inst (.enable(enable), .nextWord(nextWord), .pixelClk(pixelClkIn),
    .parWord(parPixelIn));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // Released link toggles every cycle so stale values never look valid
  always @(posedge core_clk) heldLink <= txLinkOe ? txLink : ~heldLink;
  assign rxLink = txLinkOe ? txLink : heldLink;

  task automatic fail(input string msg);
    $display("BAD %0t %s", $time, msg);
    err_count++;
  endtask
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    comparisons++;
    if (got !== exp) fail(what);
  endtask
  task automatic cmp_word(input display_link_pkg::pixel_word_t got, exp, input string what);
    comparisons++;
    if (got !== exp) fail(what);
  endtask
  task automatic cmp_num(input int got, exp, input string what);
    comparisons++;
    if (got != exp) fail(what);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Mixed word 0 first, then corner words all ones and all zeros, then mixed
  function automatic display_link_pkg::pixel_word_t word_for(input int k);
    if (k == 1) return display_link_pkg::pixel_word_t'(21'h1FFFFF);
    if (k == 2) return '0;
    return display_link_pkg::pixel_word_t'(21'(k * 21'h0C3A5) ^ 21'h0A5A5A);
  endfunction

  // Every pixel clock fall hands over one word to both halves
  always @(negedge pixelClkIn) if (tracking) begin
    txExp.push_back(parPixelIn);
    rxExp.push_back(parPixelIn);
  end

  // Wire watcher rebuilds a word once the forwarded clock frame is complete
  always @(posedge core_clk) begin
    for (int k = 0; k < 6; k++) hist[k] = hist[k + 1];
    hist[6] = txLink;
    for (int s = 0; s < 7; s++) begin
      fwdSeq[s] = hist[s].fwdClkPos;
      for (int l = 0; l < 3; l++) txWord[l * 7 + s] = hist[s].lanePos[l];
    end
    if (checking && txLinkOe && fwdSeq === display_link_pkg::FWD_PATTERN) begin
      txSeen++;
      for (int s = 0; s < 7; s++)
        cmp_bit(&({hist[s].laneNeg, hist[s].fwdClkNeg} ^ {hist[s].lanePos, hist[s].fwdClkPos}), 1'b1,
          "pair not complementary");
      if (txExp.size() > 0) cmp_word(txWord, txExp.pop_front(), "lane word");
      else fail("extra word on lanes");
    end
  end

  // Panel side: word taken at the regenerated clock fall
  always @(posedge core_clk) begin
    if (pixelClkOut === 1'b1 && prevClkOut === 1'b0) begin
      if (checking && rxSeen > 0) cmp_num(periodCyc, 8, "output clock period");
      periodCyc = 0;
      highCyc = 0;
    end
    periodCyc++;
    if (pixelClkOut === 1'b1) highCyc++;
    if (checking && pixelClkOut === 1'b0 && prevClkOut === 1'b1) begin
      rxSeen++;
      cmp_num(highCyc, display_link_pkg::RX_HIGH_CYC, "output clock high time");
      if (rxExp.size() > 0) cmp_word(parPixelOut, rxExp.pop_front(), "rebuilt word");
      else fail("extra rebuilt word");
    end
    prevClkOut = pixelClkOut;
  end

  task automatic wake_up();
    int n;
    @(posedge core_clk);
    #1 txSleepN = 1'b1;
    rxSleepN = 1'b1;
    enable = 1'b1;
    repeat (3) @(posedge core_clk);
    #1 cmp_bit(txLinkOe, 1'b1, "tx enable after wake");
    cmp_bit(rxOutOe, 1'b1, "rx enable after wake");
    cmp_bit(txLink.fwdClkPos, 1'b0, "serial out before lock");
    cmp_word(parPixelOut, '0, "parallel out before lock");
    n = 0;
    while (pixelClkOut !== 1'b1 && n < 600) begin
      @(posedge core_clk);
      n++;
    end
    cmp_bit(n < 600, 1'b1, "link never locked");
    if (n >= 600) end_of_test();
  endtask

  // Short stop drains the pipe without losing lock, then n words back to back
  task automatic stream(input int n);
    @(posedge core_clk);
    #1 enable = 1'b0;
    repeat (36) @(posedge core_clk);
    txExp.delete();
    rxExp.delete();
    txSeen = 0;
    rxSeen = 0;
    nextWord = word_for(0);
    checking = 1'b1;
    tracking = 1'b1;
    enable = 1'b1;
    for (int k = 1; k <= n; k++) begin
      @(negedge pixelClkIn);
      nextWord = word_for(k);
    end
    #1 tracking = 1'b0;
    enable = 1'b0;
    repeat (30) @(posedge core_clk);
    checking = 1'b0;
    cmp_num(txSeen, n, "words on lanes");
    cmp_num(rxSeen, n, "words rebuilt");
  endtask

  task automatic sleep_outputs();
    @(posedge core_clk);
    #1 enable = 1'b1;
    txSleepN = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 cmp_bit(txLinkOe, 1'b0, "tx enable in sleep");
    cmp_bit(rxOutOe, 1'b1, "rx enable while awake");
    rxSleepN = 1'b0;
    repeat (3) @(posedge core_clk);
    #1 cmp_bit(rxOutOe, 1'b0, "rx enable in sleep");
    wake_up();
    stream(6);
  endtask

  initial begin
    #3000000;
    fail("run timed out");
    end_of_test();
  end

  initial begin
    {resetn, txSleepN, rxSleepN, enable, tracking, checking, prevClkOut} = '0;
    nextWord = '0;
    heldLink = '0;
    {err_count, comparisons, txSeen, rxSeen, highCyc, periodCyc} = '0;
    repeat (12) @(posedge core_clk);
    #1 cmp_bit(&txLink.laneNeg, 1'b1, "lanes idle in reset");
    resetn = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 cmp_bit(txLinkOe | rxOutOe, 1'b0, "enables while asleep");
    wake_up();
    stream(24);
    sleep_outputs();
    end_of_test();
  end
endmodule // tb_display_lvds_serdes_link
